// ==== hw/hsw_pin_sync.sv ====
// Two-stage synchronisers for asynchronous status pins
// Assumes pins are unrelated to core_clk_in
`timescale 1ns/1ns
module hsw_pin_sync (
  input  wire logic  core_clk_in,
  input  wire logic  rst_n_in,
  input  wire logic  line_ok_in,
  input  wire logic  meas_done_in,
  input  wire logic  calibrating_in,
  hsw_sync_if.src    sync_out
);

  logic [2:0] stage1;
  logic [2:0] stage2;
  logic [2:0] next_stage1;
  logic [2:0] next_stage2;

  // Next values of both stages
  always_comb begin
    next_stage1 = {calibrating_in, meas_done_in, line_ok_in};
    next_stage2 = stage1;
  end

  // Stage registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= 3'h0;
      stage2 <= 3'h0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_out.line_ok     = stage2[0];
  assign sync_out.meas_done   = stage2[1];
  assign sync_out.calibrating = stage2[2];

endmodule

// ==== hw/hsw_pkg.sv ====
// Constants and types for the heater status word logic
// Assumes one core clock at 50 MHz and an active-low asynchronous reset
// Function
// - Control-active flag is 1 only after heat start accepted and control entered.
// - Reserved info flag always reads as 0.
// - Standby flag set while fault reset or measure pause request is 1.
// - After power-up, standby is 1 without alarm until line voltage first appears.
// - Line voltage lost after presence: standby 0, alarm 1, error code 201.
// - Line voltage returning keeps alarm and code 201 until acknowledged.
// - While reset request held, code 201, alarm and standby stay set.
// - Reset released with line voltage present clears alarm and standby.
// - Acknowledge while line voltage absent reports error code 901 at once.
// - After 901, line voltage on plus second acknowledge returns to control.
// - With heat start 1, gap flag set while no measurement is made.
// - Gap flag returns to 0 as soon as a measurement is made.
// - Actual temperature word is 16-bit signed, one degree per count.
// - Actual temperature word forced to 0 during calibration or fault.
// - Optional submodule returns temperature measured just before latest heat start.
// - Start temperature word reads minus 99 unless heat start is active.
// - Valid start temperatures lie between minus 20 and 500 degrees.
// - With alarm set, error code sits in bits 0 to 9 of word three.
package hsw_pkg;

  // ****************************************************************
  // Word layout and codes
  // ****************************************************************
  localparam int unsigned TEMP_WIDTH = 16;
  localparam int unsigned CODE_WIDTH = 10;
  localparam logic [9:0] CODE_NONE = 10'h000;
  localparam logic [9:0] CODE_LINE_LOST = 10'h0c9;   // 201
  localparam logic [9:0] CODE_ACK_NO_LINE = 10'h385; // 901
  localparam logic [15:0] START_TEMP_INVALID = 16'hff9d; // -99
  localparam logic signed [15:0] START_TEMP_MIN = 16'shffec; // -20
  localparam logic signed [15:0] START_TEMP_MAX = 16'sh01f4; // 500
  localparam logic [15:0] ACTUAL_FORCED = 16'h0000;

  // Line voltage supervision states
  typedef enum logic [2:0] {
    HSW_WAIT_FIRST = 3'b000,
    HSW_RUN        = 3'b001,
    HSW_LOST       = 3'b010,
    HSW_PEND_ACK   = 3'b011,
    HSW_ACK_HELD   = 3'b100,
    HSW_NO_LINE    = 3'b101
  } hsw_line_state_type;

endpackage

// ==== hw/hsw_status_word.sv ====
// Status and measurement words returned to the fieldbus master each cycle
// Holds the line-voltage fault sequence, request handshakes and start latch
// Assumes requests from master logic on the same clock; pins come in asynchronous
// Assumes the master holds each request until it sees the standby flag
`timescale 1ns/1ns
module hsw_status_word (
  input  wire logic                         core_clk_in,
  input  wire logic                         rst_n_in,
  input  wire logic                         exchange_in,
  input  wire logic                         heat_cycle_command_in,
  input  wire logic                         fault_reset_request_in,
  input  wire logic                         measure_pause_request_in,
  input  wire logic                         control_entered_in,
  input  wire logic                         start_temp_enable_in,
  input  wire logic                         other_fault_in,
  input  wire logic [hsw_pkg::TEMP_WIDTH-1:0] measured_temp_in,
  input  wire logic                         line_ok_in,
  input  wire logic                         meas_done_in,
  input  wire logic                         calibrating_in,
  output logic                              control_active_flag_out,
  output logic                              reserved_info_flag_out,
  output logic                              standby_handshake_flag_out,
  output logic                              fault_indicator_out,
  output logic                              measurement_gap_flag_out,
  output logic [hsw_pkg::CODE_WIDTH-1:0]    error_code_out,
  output logic [hsw_pkg::TEMP_WIDTH-1:0]    actual_temperature_word_out,
  output logic [hsw_pkg::TEMP_WIDTH-1:0]    start_temperature_word_out
);
  import hsw_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The fieldbus words are sixteen bits wide, one degree per count
  if (TEMP_WIDTH != 16) begin : g_temp_width_check
    $error("temperature words must be sixteen bits wide");
  end
  // The error code field spans ten bits of the third word
  if (CODE_WIDTH != 10) begin : g_code_width_check
    $error("error code field must be ten bits wide");
  end
  // The marker must sit below the valid range or the master cannot tell them apart
  if ($signed(START_TEMP_INVALID) >= START_TEMP_MIN) begin : g_marker_check
    $error("start temperature marker lies inside the valid range");
  end
  // The clamp needs a range that is not empty
  if (START_TEMP_MIN > START_TEMP_MAX) begin : g_range_check
    $error("start temperature range is empty");
  end
  // The two line-voltage codes must differ from each other, and the line-lost code from no-fault
  if (CODE_LINE_LOST == CODE_ACK_NO_LINE || CODE_LINE_LOST == CODE_NONE) begin : g_code_check
    $error("line voltage codes collide");
  end
  // Calibration and faults show a plain zero
  if (ACTUAL_FORCED != 16'h0000) begin : g_forced_check
    $error("forced actual value must be zero");
  end

  // ****************************************************************
  // Supervision state decoding
  // ****************************************************************
  // True in every supervision state that carries the line-voltage alarm
  function automatic logic state_has_alarm(input hsw_line_state_type s);
    case (s)
      HSW_LOST, HSW_PEND_ACK, HSW_ACK_HELD, HSW_NO_LINE: begin
        state_has_alarm = 1'b1;
      end
      default: begin
        state_has_alarm = 1'b0;
      end
    endcase
  endfunction

  // Error code that belongs to a supervision state
  function automatic logic [CODE_WIDTH-1:0] state_code(input hsw_line_state_type s);
    case (s)
      HSW_NO_LINE: begin
        state_code = CODE_ACK_NO_LINE;
      end
      HSW_LOST, HSW_PEND_ACK, HSW_ACK_HELD: begin
        state_code = CODE_LINE_LOST;
      end
      default: begin
        state_code = CODE_NONE;
      end
    endcase
  endfunction

  // ****************************************************************
  // Synchronised pins
  // ****************************************************************
  // Only the second flop of each synchroniser is visible here
  hsw_sync_if sync_bus ();

  hsw_pin_sync u_sync (
    .core_clk_in    (core_clk_in),
    .rst_n_in       (rst_n_in),
    .line_ok_in     (line_ok_in),
    .meas_done_in   (meas_done_in),
    .calibrating_in (calibrating_in),
    .sync_out       (sync_bus)
  );

  // ****************************************************************
  // Line voltage supervision
  // ****************************************************************
  hsw_line_state_type line_state;
  hsw_line_state_type next_line_state;
  logic               reset_seen;
  logic               next_reset_seen;

  // Next supervision state; acknowledge is the release of the reset request
  always_comb begin
    next_line_state = line_state;
    next_reset_seen = fault_reset_request_in;
    case (line_state)
      HSW_WAIT_FIRST: begin
        if (sync_bus.line_ok) begin
          next_line_state = HSW_RUN;
        end
      end
      HSW_RUN: begin
        if (!sync_bus.line_ok) begin
          next_line_state = HSW_LOST;
        end
      end
      HSW_LOST, HSW_PEND_ACK: begin
        if (fault_reset_request_in) begin
          next_line_state = sync_bus.line_ok ? HSW_ACK_HELD : HSW_LOST;
        end else if (reset_seen) begin
          next_line_state = sync_bus.line_ok ? HSW_RUN : HSW_NO_LINE;
        end else if (sync_bus.line_ok) begin
          next_line_state = HSW_PEND_ACK;
        end else begin
          next_line_state = HSW_LOST;
        end
      end
      HSW_ACK_HELD: begin
        if (!fault_reset_request_in) begin
          next_line_state = sync_bus.line_ok ? HSW_RUN : HSW_NO_LINE;
        end
      end
      HSW_NO_LINE: begin
        if (!fault_reset_request_in && reset_seen && sync_bus.line_ok) begin
          next_line_state = HSW_RUN;
        end
      end
      default: begin
        next_line_state = HSW_WAIT_FIRST;
      end
    endcase
  end

  // Supervision registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_state <= HSW_WAIT_FIRST;
      reset_seen <= 1'b0;
    end else begin
      line_state <= next_line_state;
      reset_seen <= next_reset_seen;
    end
  end

  // ****************************************************************
  // Start temperature capture
  // ****************************************************************
  logic [TEMP_WIDTH-1:0] last_temp;
  logic [TEMP_WIDTH-1:0] next_last_temp;
  logic [TEMP_WIDTH-1:0] start_temp;
  logic [TEMP_WIDTH-1:0] next_start_temp;
  logic                  cmd_prev;
  logic                  next_cmd_prev;

  // Clamp a temperature into the valid start range
  function automatic logic [TEMP_WIDTH-1:0] clamp_start(input logic [TEMP_WIDTH-1:0] t);
    if ($signed(t) < START_TEMP_MIN) begin
      clamp_start = START_TEMP_MIN;
    end else if ($signed(t) > START_TEMP_MAX) begin
      clamp_start = START_TEMP_MAX;
    end else begin
      clamp_start = t;
    end
  endfunction

  // Track last measurement and latch it at the heat start edge
  always_comb begin
    next_last_temp  = last_temp;
    next_start_temp = start_temp;
    next_cmd_prev   = heat_cycle_command_in;
    if (sync_bus.meas_done && !measure_pause_request_in) begin
      next_last_temp = measured_temp_in;
    end
    if (heat_cycle_command_in && !cmd_prev) begin
      next_start_temp = clamp_start(last_temp);
    end
  end

  // Capture registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_temp  <= ACTUAL_FORCED;
      start_temp <= START_TEMP_INVALID;
      cmd_prev   <= 1'b0;
    end else begin
      last_temp  <= next_last_temp;
      start_temp <= next_start_temp;
      cmd_prev   <= next_cmd_prev;
    end
  end

  // ****************************************************************
  // Shared fault decode
  // ****************************************************************
  logic                  line_alarm;
  logic                  fault_now;
  logic [CODE_WIDTH-1:0] code_now;

  // Alarm and code of the present supervision state
  always_comb begin
    line_alarm = state_has_alarm(line_state);
    fault_now  = line_alarm || other_fault_in;
    code_now   = state_code(line_state);
  end

  // ****************************************************************
  // Status flags, refreshed at each exchange
  // ****************************************************************
  logic next_control;
  logic next_info;
  logic next_standby;
  logic next_fault;
  logic next_gap;

  // Flags hold between exchanges and take a fresh snapshot on the strobe
  always_comb begin
    next_control = control_active_flag_out;
    next_info    = 1'b0;
    next_standby = standby_handshake_flag_out;
    next_fault   = fault_indicator_out;
    next_gap     = measurement_gap_flag_out;
    if (exchange_in) begin
      // Control only once the start is taken and control runs without fault
      next_control = heat_cycle_command_in && control_entered_in && !fault_now;
      // Standby covers the first wait for line voltage and both request handshakes
      next_standby = (line_state == HSW_WAIT_FIRST) || fault_reset_request_in ||
                     measure_pause_request_in;
      next_fault   = fault_now;
      // Gap follows the synchronised measurement strobe during a heat cycle
      next_gap     = heat_cycle_command_in && !sync_bus.meas_done;
    end
  end

  // Flag registers; standby reads 1 from power-up while line voltage is awaited
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      control_active_flag_out    <= 1'b0;
      reserved_info_flag_out     <= 1'b0;
      standby_handshake_flag_out <= 1'b1;
      fault_indicator_out        <= 1'b0;
      measurement_gap_flag_out   <= 1'b0;
    end else begin
      control_active_flag_out    <= next_control;
      reserved_info_flag_out     <= next_info;
      standby_handshake_flag_out <= next_standby;
      fault_indicator_out        <= next_fault;
      measurement_gap_flag_out   <= next_gap;
    end
  end

  // ****************************************************************
  // Error code word
  // ****************************************************************
  logic [CODE_WIDTH-1:0] next_code;

  // Code only accompanies a raised alarm; other faults report code zero
  always_comb begin
    next_code = error_code_out;
    if (exchange_in) begin
      next_code = fault_now ? code_now : CODE_NONE;
    end
  end

  // Code register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      error_code_out <= CODE_NONE;
    end else begin
      error_code_out <= next_code;
    end
  end

  // ****************************************************************
  // Actual temperature word
  // ****************************************************************
  logic [TEMP_WIDTH-1:0] next_actual;

  // Last measured value, forced to zero while calibrating or faulted
  always_comb begin
    next_actual = actual_temperature_word_out;
    if (exchange_in) begin
      if (sync_bus.calibrating || fault_now) begin
        next_actual = ACTUAL_FORCED;
      end else begin
        next_actual = last_temp;
      end
    end
  end

  // Actual word register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      actual_temperature_word_out <= ACTUAL_FORCED;
    end else begin
      actual_temperature_word_out <= next_actual;
    end
  end

  // ****************************************************************
  // Start temperature word
  // ****************************************************************
  logic [TEMP_WIDTH-1:0] next_start_word;

  // Latched value only inside a heat cycle with the submodule present;
  // the cycle that sees the start edge still shows the marker
  always_comb begin
    next_start_word = start_temperature_word_out;
    if (exchange_in) begin
      if (start_temp_enable_in && heat_cycle_command_in && cmd_prev) begin
        next_start_word = start_temp;
      end else begin
        next_start_word = START_TEMP_INVALID;
      end
    end
  end

  // Start word register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_temperature_word_out <= START_TEMP_INVALID;
    end else begin
      start_temperature_word_out <= next_start_word;
    end
  end

endmodule

// ==== hw/hsw_sync_if.sv ====
// Interface carrying synchronised pin levels between synchroniser and core
// Assumes the same clock on both sides
`timescale 1ns/1ns
interface hsw_sync_if;
  logic line_ok;
  logic meas_done;
  logic calibrating;
  modport src (output line_ok, output meas_done, output calibrating);
  modport dst (input line_ok, input meas_done, input calibrating);
endinterface

// ==== tb/hsw_master_model.sv ====
// Master side of the reset handshake
// Assumes the block's standby flag on the same clock
`timescale 1ns/1ns
module hsw_master_model (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic ack_go_in,
  input  wire logic standby_handshake_flag_in,
  output logic      fault_reset_request_out
);
  // Raise request on command, drop it only once standby confirms
  always @(negedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_reset_request_out <= 1'b0;
    end else if (ack_go_in) begin
      fault_reset_request_out <= 1'b1;
    end else if (standby_handshake_flag_in) begin
      fault_reset_request_out <= 1'b0;
    end
  end
endmodule

// ==== tb/hsw_status_properties.sv ====
// Checker for the status word block, watching only its top ports
// Assumes exchange strobe and master requests on core_clk_in
`timescale 1ns/1ns
module hsw_status_properties (
  input wire logic                          core_clk_in,
  input wire logic                          rst_n_in,
  input wire logic                          exchange_in,
  input wire logic                          heat_cycle_command_in,
  input wire logic                          fault_reset_request_in,
  input wire logic                          measure_pause_request_in,
  input wire logic                          control_entered_in,
  input wire logic                          control_active_flag_out,
  input wire logic                          reserved_info_flag_out,
  input wire logic                          standby_handshake_flag_out,
  input wire logic                          fault_indicator_out,
  input wire logic                          measurement_gap_flag_out,
  input wire logic [hsw_pkg::CODE_WIDTH-1:0] error_code_out,
  input wire logic [hsw_pkg::TEMP_WIDTH-1:0] actual_temperature_word_out,
  input wire logic [hsw_pkg::TEMP_WIDTH-1:0] start_temperature_word_out
);
  import hsw_pkg::*;
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Reset or pause request held over four exchanges
  sequence seq_req_held;
    (exchange_in && (fault_reset_request_in || measure_pause_request_in))[*4];
  endsequence
  // Reset request low for three cycles, so no acknowledge edge in the last two cycles
  sequence seq_no_ack;
    (!fault_reset_request_in)[*3];
  endsequence
  AST_INFO_ZERO: assert property (!reserved_info_flag_out)
    else $error("info flag set");
  AST_STANDBY_REQ: assert property (seq_req_held |-> standby_handshake_flag_out)
    else $error("standby missing under request");
  AST_ACTUAL_FAULT: assert property (fault_indicator_out |->
    actual_temperature_word_out == ACTUAL_FORCED) else $error("actual not forced");
  AST_CODE_ALARM: assert property (error_code_out != CODE_NONE |-> fault_indicator_out)
    else $error("code without alarm");
  AST_CONTROL_START: assert property ($rose(control_active_flag_out) |->
    $past(heat_cycle_command_in) && $past(control_entered_in)) else $error("control early");
  AST_START_IDLE: assert property ($past(exchange_in) && !$past(heat_cycle_command_in) |->
    start_temperature_word_out == START_TEMP_INVALID) else $error("start word not marker");
  AST_START_RANGE: assert property (start_temperature_word_out != START_TEMP_INVALID |->
    $signed(start_temperature_word_out) >= START_TEMP_MIN &&
    $signed(start_temperature_word_out) <= START_TEMP_MAX) else $error("start out of range");
  AST_GAP_IDLE: assert property ($past(exchange_in) && !$past(heat_cycle_command_in) |->
    !measurement_gap_flag_out) else $error("gap flag without start");
  AST_CODE_HOLD: assert property (seq_no_ack ##0 error_code_out == CODE_LINE_LOST |=>
    error_code_out == CODE_LINE_LOST) else $error("code 201 dropped without ack");
  AST_HOLD_NO_EXCH: assert property (!$past(exchange_in) |->
    $stable({control_active_flag_out, standby_handshake_flag_out, fault_indicator_out,
             measurement_gap_flag_out, error_code_out, actual_temperature_word_out,
             start_temperature_word_out})) else $error("outputs moved without exchange");
endmodule
bind hsw_status_word hsw_status_properties u_props (.*);

// ==== tb/tb.sv ====
// Self-checking bench for the status word block
// Assumes the checker is bound and the master model answers handshakes
`timescale 1ns/1ns
module tb;
  import hsw_pkg::*;
  typedef struct packed {logic cal; logic [15:0] temp; logic [15:0] actual;} hsw_row_type;
  logic        clk, rst_n, exch, cmd, pause, entered, en, ofault, line, meas, cal, go;
  logic        ctl, info, sb, flt, gap, rst_req;
  logic [9:0]  code;
  logic [15:0] temp, act, st;
  int          checks, mismatches, cyc;
  hsw_row_type rows [4] = '{'{1'b0, 16'h0019, 16'h0019}, '{1'b0, 16'hffec, 16'hffec},
                            '{1'b0, 16'h01f4, 16'h01f4}, '{1'b1, 16'h0064, 16'h0000}};
  // ****************************************************************
  // Design, master model, clock
  // ****************************************************************
  hsw_status_word dut (.core_clk_in(clk), .rst_n_in(rst_n), .exchange_in(exch),
    .heat_cycle_command_in(cmd), .fault_reset_request_in(rst_req),
    .measure_pause_request_in(pause), .control_entered_in(entered),
    .start_temp_enable_in(en), .other_fault_in(ofault), .measured_temp_in(temp),
    .line_ok_in(line), .meas_done_in(meas), .calibrating_in(cal),
    .control_active_flag_out(ctl), .reserved_info_flag_out(info),
    .standby_handshake_flag_out(sb), .fault_indicator_out(flt),
    .measurement_gap_flag_out(gap), .error_code_out(code),
    .actual_temperature_word_out(act), .start_temperature_word_out(st));
  hsw_master_model model (.core_clk_in(clk), .rst_n_in(rst_n), .ack_go_in(go),
    .standby_handshake_flag_in(sb), .fault_reset_request_out(rst_req));
  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      test_done();
    end
  end
  // Compare helpers, pacing and verdict
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One acknowledge through the master model, returns once standby shows
  task automatic ack();
    int i;
    go <= 1'b1;
    step(1);
    go <= 1'b0;
    for (i = 0; i < 20 && sb !== 1'b1; i++) step(1);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0; exch = 1'b1; en = 1'b1; temp = 16'h0000;
    {cmd, pause, entered, ofault, line, meas, cal, go} = 8'h00;
    step(20);
    chk_bit(sb, 1'b1);
    chk_word(st, START_TEMP_INVALID);
    rst_n = 1'b1;
    step(6);
    chk_bit(sb, 1'b1);
    chk_bit(flt, 1'b0);
    line = 1'b1; meas = 1'b1;
    step(6);
    chk_bit(sb, 1'b0);
    chk_bit(info, 1'b0);
    foreach (rows[i]) begin
      cal = rows[i].cal; temp = rows[i].temp;
      step(6);
      chk_word(act, rows[i].actual);
    end
    cal = 1'b0; temp = 16'h0064;
    step(6);
    cmd = 1'b1; entered = 1'b1;
    step(2);
    temp = 16'h00c8;
    step(4);
    chk_word(st, 16'h0064);
    chk_bit(ctl, 1'b1);
    meas = 1'b0;
    step(6);
    chk_bit(gap, 1'b1);
    meas = 1'b1;
    step(6);
    chk_bit(gap, 1'b0);
    cmd = 1'b0; temp = 16'h0258;
    step(6);
    chk_word(st, START_TEMP_INVALID);
    cmd = 1'b1;
    step(4);
    chk_word(st, 16'h01f4);
    en = 1'b0;
    step(2);
    chk_word(st, START_TEMP_INVALID);
    exch = 1'b0;
    cmd = 1'b0;
    temp = 16'h0032;
    step(4);
    chk_bit(ctl, 1'b1);
    chk_word(act, 16'h0258);
    exch = 1'b1;
    step(2);
    chk_bit(ctl, 1'b0);
    chk_word(act, 16'h0032);
    cmd = 1'b1;
    entered = 1'b0;
    step(2);
    chk_bit(ctl, 1'b0);
    cmd = 1'b0; pause = 1'b1;
    step(6);
    chk_bit(sb, 1'b1);
    pause = 1'b0; line = 1'b0;
    step(6);
    chk_bit(flt, 1'b1);
    chk_bit(sb, 1'b0);
    chk_word({6'h00, code}, {6'h00, CODE_LINE_LOST});
    chk_word(act, ACTUAL_FORCED);
    line = 1'b1;
    step(6);
    chk_word({6'h00, code}, {6'h00, CODE_LINE_LOST});
    ack();
    chk_word({flt, sb, 4'h0, code}, {2'b11, 4'h0, CODE_LINE_LOST});
    step(6);
    chk_word({flt, sb, 4'h0, code}, {2'b00, 4'h0, CODE_NONE});
    line = 1'b0;
    step(6);
    ack();
    step(6);
    chk_word({flt, 5'h00, code}, {1'b1, 5'h00, CODE_ACK_NO_LINE});
    line = 1'b1;
    step(6);
    ack();
    step(6);
    chk_word({flt, 5'h00, code}, {1'b0, 5'h00, CODE_NONE});
    ofault = 1'b1;
    step(6);
    chk_word({flt, act[14:0]}, {1'b1, 15'h0000});
    test_done();
  end
endmodule
